/* fcd_host.sv */
/*
  flash command host: turns one command request into the unlock and command
  write cycle sequence of the flash, in standard or alternate pin arrangement.
  assumes the flash sits on the flash_* pins and that reads (status polling,
  identification) are done by other logic while busy is low.
*/
// Notes on behaviour
// - multi-cycle commands open with AA/5555, 55/2AAA
// - program: unlock, A0/5555, then address and data
// - chip erase: unlock, 80, unlock, 10/5555
// - sector erase ends with 30 at sector
// - lockout ends with 40 at 5555
// - id entry: unlock then 90/5555
// - id exit: three-cycle or single F0 write
// - alternate arrangement uses A555, 5AAA, 2555
`timescale 1ns/1ps
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,     // command request
  output logic             cmd_ready,     // sequencer free
  input  wire fcd_op_type  cmd_op,        // which command
  input  wire logic [19:0] cmd_addr,      // program target
  input  wire logic [15:0] cmd_data,      // program data
  input  wire logic [1:0]  cmd_sector,    // 0 boot, 1 param1, 2 param2, 3 main
  input  wire logic        alt_pins,      // alternate pin arrangement
  input  wire logic        top_boot,      // top-boot variant
  output logic             cmd_done,      // pulse after last write cycle
  output logic             busy,          // sequence running
  output logic [19:0]      boot_lo,       // boot block lowest address
  output logic [19:0]      boot_hi,       // boot block highest address
  output logic [19:0]      lock_state_addr, // read here in id mode, bit 0
  input  wire logic        byte_mode,     // byte organised part
  output logic [19:0]      flash_addr,
  output logic [15:0]      flash_data_out,
  output logic             flash_data_oe,
  output logic             flash_we_n,
  output logic             flash_ce_n
);
  typedef enum logic [2:0]
  {
    FCD_S_IDLE = 3'b001,
    FCD_S_ISSUE = 3'b010,
    FCD_S_WAIT = 3'b100
  } fcd_s_type;

  fcd_cycle_if cyc ();

  fcd_s_type    st_q, st_d;       // sequencer phase
  fcd_op_type   op_q, op_d;       // latched command
  logic [2:0]   idx_q, idx_d;     // cycle index within sequence
  logic [19:0]  tgt_q, tgt_d;     // latched program address
  logic [15:0]  dat_q, dat_d;     // latched program data
  logic [1:0]   sec_q, sec_d;     // latched sector
  logic         alt_q, alt_d;     // latched arrangement
  logic         top_q, top_d;     // latched variant
  logic         done_q, done_d;   // completion pulse
  logic [2:0]   last_idx;         // final index of current sequence
  logic [19:0]  c_addr;           // address of current cycle
  logic [15:0]  c_data;           // data of current cycle
  logic [15:0]  a1, a2, a4;       // command addresses for arrangement
  logic [7:0]   sec_hi;           // sector select address bits 19:12

  // command addresses; upper bits and byte lsb left zero as don't-care
  always_comb
  begin
    a1 = alt_q ? ALT_ADDR1 : STD_ADDR1;
    a2 = alt_q ? ALT_ADDR2 : STD_ADDR2;
    a4 = alt_q ? ALT_ADDR4 : STD_ADDR4;
  end

  // sector select address from arrangement and boot variant
  always_comb
  begin
    unique case ({alt_q, top_q})
      2'b00: sec_hi = SEC_STD_BOT[sec_q];
      2'b01: sec_hi = SEC_STD_TOP[sec_q];
      2'b10: sec_hi = SEC_ALT_BOT[sec_q];
      2'b11: sec_hi = SEC_ALT_TOP[sec_q];
    endcase
  end

  // boot block bounds shown to the user for software lockout checks
  always_comb
  begin
    boot_lo         = '0;
    boot_hi         = byte_mode ? BOOT_BYTE_BOT_HI : BOOT_WORD_BOT_HI;
    lock_state_addr = LOCK_STATE_OFS;
    if (top_boot)
    begin
      boot_lo         = BOOT_WORD_TOP_LO;
      boot_hi         = BOOT_WORD_TOP_HI;
      lock_state_addr = LOCK_STATE_TOP;
    end
  end

  // sequence length per command
  always_comb
  begin
    unique case (op_q)
      FCD_OP_PROGRAM: last_idx = 3'd3;
      FCD_OP_ID_IN:   last_idx = 3'd2;
      FCD_OP_ID_OUT3: last_idx = 3'd2;
      FCD_OP_ID_OUT1: last_idx = 3'd0;
      default:        last_idx = 3'd5;
    endcase
  end

  // address and data of each cycle; upper data byte sent as zero except in the program data cycle
  always_comb
  begin
    c_addr = '0;
    c_data = '0;
    if (op_q == FCD_OP_ID_OUT1)
    begin
      c_data = {8'h00, CODE_ID_EXIT};
    end
    else
    begin
      unique case (idx_q)
        3'd0:
        begin
          c_addr = {4'h0, a1};
          c_data = {8'h00, CODE_UNLOCK1};
        end
        3'd1, 3'd4:
        begin
          c_addr = {4'h0, a2};
          c_data = {8'h00, CODE_UNLOCK2};
        end
        3'd2:
        begin
          c_addr = {4'h0, a1};
          unique case (op_q)
            FCD_OP_PROGRAM: c_data = {8'h00, CODE_PROGRAM};
            FCD_OP_ID_IN:   c_data = {8'h00, CODE_ID_ENTRY};
            FCD_OP_ID_OUT3: c_data = {8'h00, CODE_ID_EXIT};
            default:        c_data = {8'h00, CODE_ERASE};
          endcase
        end
        3'd3:
        begin
          if (op_q == FCD_OP_PROGRAM)
          begin
            c_addr = tgt_q;
            c_data = dat_q;
          end
          else
          begin
            c_addr = {4'h0, a4};
            c_data = {8'h00, CODE_UNLOCK1};
          end
        end
        default:
        begin
          c_addr = {4'h0, a1};
          unique case (op_q)
            FCD_OP_SECTOR:
            begin
              c_addr = {sec_hi, 12'h000};
              c_data = {8'h00, CODE_SECTOR};
            end
            FCD_OP_LOCKOUT: c_data = {8'h00, CODE_LOCKOUT};
            default:        c_data = {8'h00, CODE_CHIP};
          endcase
        end
      endcase
    end
  end

  // sequencer: a whole command runs back to back, no foreign cycle between
  always_comb
  begin
    st_d   = st_q;
    op_d   = op_q;
    idx_d  = idx_q;
    tgt_d  = tgt_q;
    dat_d  = dat_q;
    sec_d  = sec_q;
    alt_d  = alt_q;
    top_d  = top_q;
    done_d = 1'b0;
    unique case (st_q)
      FCD_S_IDLE:
      begin
        if (cmd_valid)
        begin
          op_d  = cmd_op;
          tgt_d = cmd_addr;
          dat_d = cmd_data;
          sec_d = cmd_sector;
          alt_d = alt_pins;
          top_d = top_boot;
          idx_d = '0;
          st_d  = FCD_S_ISSUE;
        end
      end
      FCD_S_ISSUE:
      begin
        if (cyc.idle)
        begin
          st_d = FCD_S_WAIT;
        end
      end
      FCD_S_WAIT:
      begin
        if (cyc.done)
        begin
          if (idx_q == last_idx)
          begin
            done_d = 1'b1;
            st_d   = FCD_S_IDLE;
          end
          else
          begin
            idx_d = idx_q + 3'd1;
            st_d  = FCD_S_ISSUE;
          end
        end
      end
    endcase
  end

  // register stage
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q   <= FCD_S_IDLE;
      op_q   <= FCD_OP_PROGRAM;
      idx_q  <= '0;
      tgt_q  <= '0;
      dat_q  <= '0;
      sec_q  <= '0;
      alt_q  <= 1'b0;
      top_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      op_q   <= op_d;
      idx_q  <= idx_d;
      tgt_q  <= tgt_d;
      dat_q  <= dat_d;
      sec_q  <= sec_d;
      alt_q  <= alt_d;
      top_q  <= top_d;
      done_q <= done_d;
    end
  end

  assign cyc.start = (st_q == FCD_S_ISSUE) && cyc.idle;
  assign cyc.addr  = c_addr;
  assign cyc.data  = c_data;
  assign cmd_ready = (st_q == FCD_S_IDLE);
  assign busy      = (st_q != FCD_S_IDLE);
  assign cmd_done  = done_q;

  // write strobe timing, one cycle at a time
  fcd_write_cycle u_cycle
  (
    .clock          (clock),
    .rstn           (rstn),
    .cyc            (cyc),
    .flash_addr     (flash_addr),
    .flash_data_out (flash_data_out),
    .flash_data_oe  (flash_data_oe),
    .flash_we_n     (flash_we_n),
    .flash_ce_n     (flash_ce_n)
  );
endmodule

/* fcd_pkg.sv */
/*
  package of the flash command host: command codes, unlock addresses,
  sector addresses and bus cycle timing.
  assumes a 25 MHz clock and a flash device with asynchronous write cycles.
*/
package fcd_pkg;
  // clock rate and bus cycle timing
  localparam int unsigned CLOCK_HZ      = 25000000;
  localparam int unsigned SETUP_NS      = 80;   // address setup before we low
  localparam int unsigned PULSE_NS      = 120;  // we low width
  localparam int unsigned HOLD_NS       = 80;   // data hold after we high
  localparam int unsigned SETUP_CYC     = (SETUP_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned PULSE_CYC     = (PULSE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned HOLD_CYC      = (HOLD_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W         = 4;

  // command codes on the low data byte
  localparam logic [7:0] CODE_UNLOCK1   = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2   = 8'h55;
  localparam logic [7:0] CODE_PROGRAM   = 8'ha0;
  localparam logic [7:0] CODE_ERASE     = 8'h80;
  localparam logic [7:0] CODE_CHIP      = 8'h10;
  localparam logic [7:0] CODE_SECTOR    = 8'h30;
  localparam logic [7:0] CODE_LOCKOUT   = 8'h40;
  localparam logic [7:0] CODE_ID_ENTRY  = 8'h90;
  localparam logic [7:0] CODE_ID_EXIT   = 8'hf0;

  // command addresses, standard and alternate pin arrangements
  localparam logic [15:0] STD_ADDR1     = 16'h5555;
  localparam logic [15:0] STD_ADDR2     = 16'h2aaa;
  localparam logic [15:0] STD_ADDR4     = 16'h5555;
  localparam logic [15:0] ALT_ADDR1     = 16'ha555;
  localparam logic [15:0] ALT_ADDR2     = 16'h5aaa;
  localparam logic [15:0] ALT_ADDR4     = 16'h2555;

  // sector select address bits 19:12, per arrangement and boot variant
  localparam logic [7:0] SEC_STD_BOT [4] = '{8'h01, 8'h02, 8'h03, 8'h7f};
  localparam logic [7:0] SEC_STD_TOP [4] = '{8'h7f, 8'h7d, 8'h7c, 8'h7b};
  localparam logic [7:0] SEC_ALT_BOT [4] = '{8'h02, 8'h04, 8'h06, 8'hfe};
  localparam logic [7:0] SEC_ALT_TOP [4] = '{8'hfe, 8'hfa, 8'h78, 8'h76};

  // boot block bounds
  localparam logic [19:0] BOOT_BYTE_BOT_HI = 20'h03fff;
  localparam logic [19:0] BOOT_WORD_BOT_HI = 20'h01fff;
  localparam logic [19:0] BOOT_WORD_TOP_LO = 20'h7e000;
  localparam logic [19:0] BOOT_WORD_TOP_HI = 20'h7ffff;
  localparam logic [19:0] LOCK_STATE_OFS   = 20'h00002;
  localparam logic [19:0] LOCK_STATE_TOP   = 20'h7e002;

  // host commands
  typedef enum logic [2:0]
  {
    FCD_OP_PROGRAM = 3'h0,
    FCD_OP_CHIP    = 3'h1,
    FCD_OP_SECTOR  = 3'h2,
    FCD_OP_LOCKOUT = 3'h3,
    FCD_OP_ID_IN   = 3'h4,
    FCD_OP_ID_OUT3 = 3'h5,
    FCD_OP_ID_OUT1 = 3'h6
  } fcd_op_type;
endpackage

/* fcd_cycle_if.sv */
/*
  interface between the sequencer and the single write cycle engine.
  assumes one clock; start is a one-cycle pulse taken only while idle.
*/
`timescale 1ns/1ps
interface fcd_cycle_if;
  logic        start;  // one write cycle request
  logic [19:0] addr;   // cycle address
  logic [15:0] data;   // cycle data
  logic        done;   // pulse after we rises and hold ends
  logic        idle;   // engine free

  modport seq (output start, output addr, output data, input done, input idle);
  modport eng (input start, input addr, input data, output done, output idle);
endinterface

/* fcd_write_cycle.sv */
/*
  one asynchronous flash write cycle: address and data out, we low, we high.
  assumes the sequencer holds addr and data steady while the cycle runs.
*/
`timescale 1ns/1ps
module fcd_write_cycle
  import fcd_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rstn,
  fcd_cycle_if.eng   cyc,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_data_out,
  output logic        flash_data_oe,
  output logic        flash_we_n,
  output logic        flash_ce_n
);
  typedef enum logic [3:0]
  {
    FCD_W_IDLE  = 4'b0001,
    FCD_W_SETUP = 4'b0010,
    FCD_W_PULSE = 4'b0100,
    FCD_W_HOLD  = 4'b1000
  } fcd_w_type;

  fcd_w_type          st_q, st_d;       // cycle phase
  logic [CNT_W-1:0]   cnt_q, cnt_d;     // phase length counter
  logic [19:0]        addr_q, addr_d;   // pin address
  logic [15:0]        data_q, data_d;   // pin data
  logic               we_n_q, we_n_d;   // write strobe
  logic               oe_q, oe_d;       // data drive
  logic               done_q, done_d;   // end pulse

  // next phase; address settles before we falls, data held after it rises
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    we_n_d = we_n_q;
    oe_d   = oe_q;
    done_d = 1'b0;
    unique case (st_q)
      FCD_W_IDLE:
      begin
        if (cyc.start)
        begin
          addr_d = cyc.addr;
          data_d = cyc.data;
          oe_d   = 1'b1;
          cnt_d  = CNT_W'(SETUP_CYC);
          st_d   = FCD_W_SETUP;
        end
      end
      FCD_W_SETUP:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == CNT_W'(1))
        begin
          we_n_d = 1'b0;  // device latches address here
          cnt_d  = CNT_W'(PULSE_CYC);
          st_d   = FCD_W_PULSE;
        end
      end
      FCD_W_PULSE:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == CNT_W'(1))
        begin
          we_n_d = 1'b1;  // device latches data here
          cnt_d  = CNT_W'(HOLD_CYC);
          st_d   = FCD_W_HOLD;
        end
      end
      FCD_W_HOLD:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == CNT_W'(1))
        begin
          oe_d   = 1'b0;
          done_d = 1'b1;
          st_d   = FCD_W_IDLE;
        end
      end
    endcase
  end

  // register stage
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q   <= FCD_W_IDLE;
      cnt_q  <= '0;
      addr_q <= '0;
      data_q <= '0;
      we_n_q <= 1'b1;
      oe_q   <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      we_n_q <= we_n_d;
      oe_q   <= oe_d;
      done_q <= done_d;
    end
  end

  assign cyc.done       = done_q;
  assign cyc.idle       = (st_q == FCD_W_IDLE) && !done_q;
  assign flash_addr     = addr_q;
  assign flash_data_out = data_q;
  assign flash_data_oe  = oe_q;
  assign flash_we_n     = we_n_q;
  assign flash_ce_n     = !oe_q;  // chip selected only around a write
endmodule

/* fcd_host_checker.sv */
/*
  checker of the flash command host: write cycle shape and handshake.
  assumes one clock domain and a bind from the bench top file.
*/
`timescale 1ns/1ps
module fcd_host_checker
  import fcd_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        cmd_done,
  input wire logic        busy,
  input wire logic        top_boot,
  input wire logic        byte_mode,
  input wire logic [19:0] boot_lo,
  input wire logic [19:0] boot_hi,
  input wire logic [19:0] lock_state_addr,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_data_out,
  input wire logic        flash_data_oe,
  input wire logic        flash_we_n,
  input wire logic        flash_ce_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // we low for exactly three clocks, then high
  sequence we_low_s;
    !flash_we_n [*3] ##1 flash_we_n;
  endsequence

  // bus still driven, data unchanged, one clock after we rises
  sequence hold_s;
    flash_data_oe ##1 (flash_data_oe && $stable(flash_data_out));
  endsequence

  pulse_width_a: assert property ($fell(flash_we_n) |-> we_low_s)
    else $error("write pulse width wrong");
  data_hold_a: assert property ($rose(flash_we_n) |-> hold_s)
    else $error("data not held after write");
  addr_setup_a: assert property ($fell(flash_we_n) |-> $past(flash_data_oe, 2) && $stable(flash_addr))
    else $error("address setup too short");
  pulse_stable_a: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_data_out))
    else $error("bus moved during write pulse");
  select_drive_a: assert property ((flash_ce_n == !flash_data_oe) && (flash_we_n || !flash_ce_n))
    else $error("chip select and drive disagree");
  take_busy_a: assert property (cmd_valid && cmd_ready |=> busy)
    else $error("command taken without busy");
  done_pulse_a: assert property (cmd_done |-> cmd_ready ##1 !cmd_done)
    else $error("done not a single pulse");
  seq_bound_a: assert property ($rose(busy) |-> ##[7:120] cmd_done)
    else $error("sequence did not finish");
  idle_quiet_a: assert property (!busy |-> flash_we_n)
    else $error("write pulse while idle");
  boot_bottom_a: assert property (!top_boot |-> boot_lo == 20'h00000 && lock_state_addr == 20'h00002
    && boot_hi == (byte_mode ? 20'h03fff : 20'h01fff))
    else $error("bottom boot bounds wrong");
  boot_top_a: assert property (top_boot |-> boot_lo == 20'h7e000 && boot_hi == 20'h7ffff
    && lock_state_addr == 20'h7e002)
    else $error("top boot bounds wrong");
endmodule

/* fcd_flash_model.sv */
/*
  behavioural flash device: logs every write cycle and decodes the unlock
  prefix with identification entry and exit, and the status bits of a program.
  assumes address taken at we fall, data at we rise, chip select low.
*/
`timescale 1ns/1ps
module fcd_flash_model
(
  input wire logic        alt_pins,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_data_out,
  input wire logic        flash_data_oe,
  input wire logic        flash_we_n,
  input wire logic        flash_ce_n
);
  logic [19:0] la[$];   // logged cycle addresses
  logic [15:0] ld[$];   // logged cycle data
  logic [19:0] a_q;     // address taken at we fall
  logic [15:0] d;       // data at we rise
  logic [15:0] c1;      // first unlock address
  logic [15:0] c2;      // second unlock address
  logic [1:0]  step;    // unlock cycles matched
  logic        id_mode; // identification reads active
  logic        arm_q;   // program code seen, next cycle loads
  logic        busy_q;  // embedded program running
  logic        poll_q;  // complement of loaded bit 7
  logic        tog_q;   // toggle bit, flips per status read

  assign c1 = alt_pins ? 16'ha555 : 16'h5555;
  assign c2 = alt_pins ? 16'h5aaa : 16'h2aaa;

  initial
  begin
    step = 2'd0;
    id_mode = 1'b0;
    arm_q = 1'b0;
    busy_q = 1'b0;
    poll_q = 1'b0;
    tog_q = 1'b0;
  end

  // status read; the program is taken as finished after the second read
  task automatic poll(output logic [1:0] s);
    s = {busy_q ? poll_q : !poll_q, tog_q};
    tog_q = !tog_q;
    busy_q = tog_q;
  endtask

  // address on the falling edge
  always @(negedge flash_we_n)
    if (!flash_ce_n)
      a_q = flash_addr;

  // data on the rising edge; a released bus logs as unknown so it never matches
  always @(posedge flash_we_n)
    if (!flash_ce_n)
    begin
      d = flash_data_oe ? flash_data_out : 16'hxxxx;
      la.push_back(a_q);
      ld.push_back(d);
      // the cycle after a recognised program code is the load itself
      if (arm_q)
      begin
        busy_q = 1'b1;
        poll_q = !d[7];
        tog_q = 1'b0;
      end
      arm_q = step == 2'd2 && a_q[15:0] == c1 && d[7:0] == 8'ha0;
      // only the low data byte and address bits 15:0 take part
      if (step == 2'd2 && a_q[15:0] == c1 && d[7:0] == 8'h90)
        id_mode = 1'b1;
      if (d[7:0] == 8'hf0)
        id_mode = 1'b0;
      // any cycle off the expected one restarts the prefix
      if (step == 2'd1 && a_q[15:0] == c2 && d[7:0] == 8'h55)
        step = 2'd2;
      else
        step = (a_q[15:0] == c1 && d[7:0] == 8'haa) ? 2'd1 : 2'd0;
    end
endmodule

/* tb_top.sv */
/*
  bench of the flash command host against the flash model.
  assumes the host sends whole command sequences on the flash pins.
*/
`timescale 1ns/1ps
module tb_top;
  import fcd_pkg::*;
  logic        clock, rstn, cmd_valid, cmd_ready, cmd_done, busy;
  logic        alt_pins, top_boot, byte_mode, flash_data_oe, flash_we_n, flash_ce_n;
  fcd_op_type  cmd_op;
  logic [1:0]  cmd_sector;
  logic [19:0] cmd_addr, boot_lo, boot_hi, lock_state_addr, flash_addr;
  logic [15:0] cmd_data, flash_data_out;
  int          n_mismatch, cmp_count;
  logic [19:0] ea[$];  // expected cycle addresses
  logic [15:0] ed[$];  // expected cycle data
  // sector codes, index {alternate, top boot}
  logic [7:0]  sec_tab [4][4] = '{'{8'h01, 8'h02, 8'h03, 8'h7f}, '{8'h7f, 8'h7d, 8'h7c, 8'h7b},
                                 '{8'h02, 8'h04, 8'h06, 8'hfe}, '{8'hfe, 8'hfa, 8'h78, 8'h76}};

  fcd_host i_dut (.clock, .rstn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .cmd_sector,
    .alt_pins, .top_boot, .cmd_done, .busy, .boot_lo, .boot_hi, .lock_state_addr, .byte_mode,
    .flash_addr, .flash_data_out, .flash_data_oe, .flash_we_n, .flash_ce_n);
  fcd_flash_model i_flash (.alt_pins, .flash_addr, .flash_data_out, .flash_data_oe, .flash_we_n, .flash_ce_n);

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(logic [35:0] got, logic [35:0] exp, string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a wait that ran out ends the run
  task automatic give_up(int k);
    if (k >= 300)
    begin
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask

  function automatic logic [19:0] a1(logic alt);
    return alt ? 20'h0a555 : 20'h05555;
  endfunction

  task automatic push(logic [19:0] a, logic [15:0] d);
    ea.push_back(a);
    ed.push_back(d);
  endtask

  // second unlock of a six-cycle command opens at 2555 in alternate mode
  task automatic unlock(logic alt, logic second);
    push(alt && second ? 20'h02555 : a1(alt), 16'h00aa);
    push(alt ? 20'h05aaa : 20'h02aaa, 16'h0055);
  endtask

  // request held until taken at an edge with ready high
  task automatic start(fcd_op_type op, logic [1:0] sec, logic alt, logic top);
    int k;
    @(posedge clock);
    #1;
    cmd_op = op;
    cmd_sector = sec;
    alt_pins = alt;
    top_boot = top;
    cmd_valid = 1'b1;
    for (k = 0; k < 300 && cmd_ready !== 1'b1; k++)
      @(posedge clock) #1;
    give_up(k);
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
  endtask

  task automatic finish_cmd();
    int k;
    for (k = 0; k < 300 && cmd_done !== 1'b1; k++)
      @(posedge clock) #1;
    give_up(k);
  endtask

  // logged cycles against expected ones, then both cleared
  task automatic cmp_log(string what);
    chk(36'(i_flash.la.size()), 36'(ea.size()), what);
    foreach (ea[i])
      if (i < i_flash.la.size())
        chk({i_flash.la[i], i_flash.ld[i]}, {ea[i], ed[i]}, what);
    ea.delete();
    ed.delete();
    i_flash.la.delete();
    i_flash.ld.delete();
    $display("test %s done", what);
  endtask

  task automatic run(fcd_op_type op, logic [1:0] sec, logic alt, logic top, string what);
    start(op, sec, alt, top);
    finish_cmd();
    cmp_log(what);
  endtask

  task automatic t_program(logic alt);
    logic [1:0] st1, st2;  // two status reads: bit 7, bit 6
    cmd_addr = alt ? 20'hc3a5b : 20'h3c5a4;
    cmd_data = alt ? 16'hbe5a : 16'h41a5;
    unlock(alt, 1'b0);
    push(a1(alt), 16'h00a0);
    push(cmd_addr, cmd_data);
    run(FCD_OP_PROGRAM, 2'd0, alt, 1'b0, "program");
    i_flash.poll(st1);
    i_flash.poll(st2);
    chk(36'(st1[1]), 36'(!cmd_data[7]), "poll bit");
    chk(36'(st1[0] ^ st2[0]), 36'h1, "toggle bit");
  endtask

  task automatic t_six(fcd_op_type op, logic alt, logic top, logic [1:0] sec);
    unlock(alt, 1'b0);
    push(a1(alt), 16'h0080);
    unlock(alt, 1'b1);
    case (op)
      FCD_OP_CHIP:    push(a1(alt), 16'h0010);
      FCD_OP_LOCKOUT: push(a1(alt), 16'h0040);
      default:        push({sec_tab[{alt, top}][sec], 12'h000}, 16'h0030);
    endcase
    byte_mode = sec[0];
    run(op, sec, alt, top, "six cycle");
  endtask

  task automatic t_ident(logic alt);
    unlock(alt, 1'b0);
    push(a1(alt), 16'h0090);
    run(FCD_OP_ID_IN, 2'd0, alt, 1'b0, "id entry");
    chk(36'(i_flash.id_mode), 36'h1, "id entered");
    unlock(alt, 1'b0);
    push(a1(alt), 16'h00f0);
    run(FCD_OP_ID_OUT3, 2'd0, alt, 1'b0, "id exit three");
    chk(36'(i_flash.id_mode), 36'h0, "id left");
    unlock(alt, 1'b0);
    push(a1(alt), 16'h0090);
    run(FCD_OP_ID_IN, 2'd0, alt, 1'b0, "id entry again");
    push(20'h00000, 16'h00f0);
    run(FCD_OP_ID_OUT1, 2'd0, alt, 1'b0, "id exit single");
    chk(36'(i_flash.id_mode), 36'h0, "id left single");
  endtask

  // a request raised while busy must not add cycles
  task automatic t_refuse();
    cmd_addr = 20'h00123;
    cmd_data = 16'h1234;
    unlock(1'b0, 1'b0);
    push(20'h05555, 16'h00a0);
    push(20'h00123, 16'h1234);
    start(FCD_OP_PROGRAM, 2'd0, 1'b0, 1'b0);
    @(posedge clock);
    #1;
    cmd_op = FCD_OP_CHIP;
    cmd_valid = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    finish_cmd();
    cmp_log("refused request");
  endtask

  // reset in mid sequence releases the pins at once
  task automatic t_reset();
    start(FCD_OP_CHIP, 2'd0, 1'b0, 1'b0);
    repeat (20) @(posedge clock);
    #1;
    rstn = 1'b0;
    #1;
    chk({flash_we_n, flash_ce_n, flash_data_oe, cmd_ready, cmd_done}, 5'b11010, "pins in reset");
    @(posedge clock);
    #1;
    rstn = 1'b1;
    i_flash.la.delete();
    i_flash.ld.delete();
    $display("test reset done");
  endtask

  initial
  begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = FCD_OP_PROGRAM;
    cmd_addr = 20'h00000;
    cmd_data = 16'h0000;
    cmd_sector = 2'd0;
    alt_pins = 1'b0;
    top_boot = 1'b0;
    byte_mode = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      t_program(a[0]);
      t_six(FCD_OP_CHIP, a[0], 1'b0, 2'd0);
      t_six(FCD_OP_LOCKOUT, a[0], 1'b1, 2'd0);
      for (int s = 0; s < 8; s++)
        t_six(FCD_OP_SECTOR, a[0], s[2], s[1:0]);
      t_ident(a[0]);
    end
    t_refuse();
    t_reset();
    t_program(1'b0);
    end_of_test();
  end
endmodule

bind fcd_host fcd_host_checker i_chk (.clock, .rstn, .cmd_valid, .cmd_ready, .cmd_done, .busy, .top_boot,
  .byte_mode, .boot_lo, .boot_hi, .lock_state_addr, .flash_addr, .flash_data_out, .flash_data_oe,
  .flash_we_n, .flash_ce_n);
